//--- hw/ampseq_top.sv
// host sequencer driving the amplifier's reset, power-down and two-wire bus pins
// What this block does
// - hold every amplifier input low before start
// - reset low 100us, release, wait 13.5ms
// - trim oscillator, then wait 50ms
// - trim, then configure, then exit shutdown
// - normal operation: volume, mute, shutdown only
// - shutdown changes wait 240ms+1.3 tstart
// - extra guard only after first trim
// - enter shutdown, wait 1ms+1.3 tstop
// - from shutdown, reconfiguration is allowed
// - exit shutdown, wait 1ms+1.3 tstart
// - start/stop times come from timing register
// - power loss: power-down low, wait 2ms
// - reset low 2us before inputs go low
`timescale 1ns/1ps
`default_nettype none
module ampseq_top
    import ampseq_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR     = 7'h2A, // arbitrary value
    parameter logic [7:0] VOL_FIRST    = 8'h07,
    parameter logic [7:0] VOL_LAST     = 8'h0A,
    parameter logic [7:0] MUTE_SUB     = 8'h06,
    parameter int         TICK_CYC     = TICK_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    output logic             amp_reset_n,
    output logic             power_down_n,
    output logic             dig_inputs_en,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);
    initial begin
        if (TICK_CYC < 1 || TICK_CYC > 65535) $error("TICK_CYC out of range");
        if (VOL_FIRST > VOL_LAST) $error("volume range reversed");
    end

    function automatic logic [15:0] wait_ticks(input int n);
        // one spare tick: the first tick may fall right after the load
        return 16'(n + 1);
    endfunction : wait_ticks

    function automatic logic [15:0] pwm_wait(input int base, input logic [7:0] t_ms);
        return 16'(base + 1) + 16'(PWM_SCALE_TICKS) * {8'h00, t_ms};
    endfunction : pwm_wait

    logic          rst_s1_q, rst_n;
    ampseq_state_e st_q, st_d;
    logic [15:0]   tick_cnt_q, tick_cnt_d;
    logic          tick;
    logic [15:0]   wait_q, wait_d, guard_q, guard_d, timing_q, timing_d;
    logic [2:0]    cmd_q, cmd_d;
    logic          pw_q, pw_d, pd_pend_q, pd_pend_d, first_q, first_d, refused_q, refused_d;
    logic [15:0]   pw_word_q, pw_word_d, rdata_d;
    logic          go_q, go_d;
    logic [7:0]    sub_q, sub_d, dat_q, dat_d;
    logic          rst_out_q, rst_out_d, pdn_q, pdn_d, den_q, den_d;
    logic          i2c_busy, i2c_done, i2c_nack, eng_free, wait_done, powered, pw_ok;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    ampseq_i2c_wr u_i2c (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .hold_low (st_q == S_OFF),
        .go       (go_q),
        .dev_addr (DEV_ADDR),
        .sub      (sub_q),
        .dat      (dat_q),
        .sda_i    (sda_i),
        .busy_q   (i2c_busy),
        .done_q   (i2c_done),
        .nack_q   (i2c_nack),
        .scl_oe_q (scl_oe),
        .sda_oe_q (sda_oe)
    );
    // open-drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    assign tick      = (tick_cnt_q == 16'h0000);
    assign wait_done = (wait_q == 16'h0000);
    assign eng_free  = !i2c_busy && !go_q;
    assign powered   = (st_q != S_OFF) && (st_q != S_LOSS) && (st_q != S_RSTLOW);
    // in normal operation only volume and soft-mute writes go out
    assign pw_ok = (st_q != S_RUN) || (pw_word_q[15:8] == MUTE_SUB) ||
                   (pw_word_q[15:8] >= VOL_FIRST && pw_word_q[15:8] <= VOL_LAST);

    always_comb begin
        st_d       = st_q;
        tick_cnt_d = tick ? 16'(TICK_CYC - 1) : tick_cnt_q - 16'h0001;
        wait_d     = (tick && !wait_done) ? wait_q - 16'h0001 : wait_q;
        guard_d    = (tick && guard_q != 16'h0000) ? guard_q - 16'h0001 : guard_q;
        timing_d   = timing_q;
        cmd_d      = cmd_q;
        pw_d       = pw_q;
        pw_word_d  = pw_word_q;
        pd_pend_d  = pd_pend_q;
        first_d    = first_q;
        refused_d  = refused_q;
        go_d       = 1'b0;
        sub_d      = sub_q;
        dat_d      = dat_q;
        rst_out_d  = rst_out_q;
        pdn_d      = pdn_q;
        den_d      = den_q;
        rdata_d    = 16'h0000;
        // software port
        if (rd) begin
            case (addr)
                REG_CTRL:   rdata_d = {13'h0000, cmd_q};
                REG_WRITE:  rdata_d = pw_word_q;
                REG_TIMING: rdata_d = timing_q;
                REG_STATUS: rdata_d = {7'h00, pw_q, i2c_busy, guard_q != 16'h0000, first_q,
                                       refused_q, i2c_nack, 3'h0} | {12'h000, st_q};
                default:    rdata_d = 16'h0000;
            endcase
        end
        if (wr && addr == REG_STATUS && wdata[ST_REFUSED_BIT]) refused_d = 1'b0;
        if (wr && addr == REG_TIMING) timing_d = wdata;
        if (wr && addr == REG_CTRL) begin
            if (cmd_q != CMD_NONE) refused_d = 1'b1;
            else cmd_d = wdata[2:0];
        end
        if (wr && addr == REG_WRITE) begin
            if (pw_q) refused_d = 1'b1;
            else begin
                pw_d      = 1'b1;
                pw_word_d = wdata;
            end
        end
        // a sudden power loss overrides whatever is in flight, but is refused while another command is pending
        if (cmd_q == CMD_LOSS && powered) begin
            cmd_d  = CMD_NONE;
            pdn_d  = 1'b0;
            wait_d = wait_ticks(TK_LOSS);
            st_d   = S_LOSS;
        end else begin
            case (st_q)
                S_OFF: begin
                    rst_out_d = 1'b0;
                    pdn_d     = 1'b0;
                    den_d     = 1'b0;
                    pd_pend_d = 1'b0;
                    if (cmd_q == CMD_INIT) begin
                        cmd_d  = CMD_NONE;
                        pdn_d  = 1'b1;
                        den_d  = 1'b1;
                        wait_d = wait_ticks(TK_RST_LOW);
                        st_d   = S_RST;
                    end else if (cmd_q != CMD_NONE) begin
                        cmd_d     = CMD_NONE;
                        refused_d = 1'b1;
                    end
                end
                S_RST: if (wait_done) begin
                    rst_out_d = 1'b1;
                    wait_d    = wait_ticks(TK_RST_REL);
                    st_d      = S_REL;
                end
                S_REL: if (wait_done && eng_free) begin
                    go_d  = 1'b1;
                    sub_d = DEV_OSC_TRIM;
                    dat_d = TRIM_VALUE;
                    st_d  = S_TRIM;
                end
                S_TRIM: if (i2c_done) begin
                    wait_d = wait_ticks(TK_TRIM);
                    if (!first_q) begin
                        first_d = 1'b1;
                        guard_d = pwm_wait(TK_GUARD, timing_q[7:0]);
                    end
                    st_d = S_TRIMW;
                end
                S_TRIMW: if (wait_done) st_d = S_CFG;
                S_EXIT: if (i2c_done) begin
                    wait_d = pwm_wait(TK_SD, timing_q[7:0]);
                    st_d   = S_EXITW;
                end
                S_EXITW: if (wait_done) st_d = S_RUN;
                S_ENTER: if (i2c_done) begin
                    wait_d = pwm_wait(TK_SD, timing_q[15:8]);
                    st_d   = S_ENTERW;
                end
                S_ENTERW: if (wait_done) begin
                    if (pd_pend_q) begin
                        rst_out_d = 1'b0;
                        wait_d    = wait_ticks(TK_RST_HOLD);
                        st_d      = S_RSTLOW;
                    end else begin
                        st_d = S_SHUT;
                    end
                end
                S_CFG, S_SHUT, S_RUN: begin
                    if (pw_q && eng_free && cmd_q == CMD_NONE) begin
                        pw_d = 1'b0;
                        if (pw_ok) begin
                            go_d  = 1'b1;
                            sub_d = pw_word_q[15:8];
                            dat_d = pw_word_q[7:0];
                        end else begin
                            refused_d = 1'b1;
                        end
                    end else if (cmd_q != CMD_NONE && eng_free) begin
                        if ((cmd_q == CMD_EXIT && st_q != S_RUN) ||
                            ((cmd_q == CMD_ENTER || cmd_q == CMD_PDOWN) && st_q == S_RUN)) begin
                            // held pending until the post-trim guard has run out
                            if (guard_q == 16'h0000) begin
                                cmd_d     = CMD_NONE;
                                go_d      = 1'b1;
                                sub_d     = DEV_SHUTDOWN_CTRL;
                                pd_pend_d = (cmd_q == CMD_PDOWN);
                                dat_d     = (cmd_q == CMD_EXIT) ? SHUTDOWN_EXIT : SHUTDOWN_ENTER;
                                st_d      = (cmd_q == CMD_EXIT) ? S_EXIT : S_ENTER;
                            end
                        end else if (cmd_q == CMD_PDOWN) begin
                            cmd_d     = CMD_NONE;
                            rst_out_d = 1'b0;
                            wait_d    = wait_ticks(TK_RST_HOLD);
                            st_d      = S_RSTLOW;
                        end else begin
                            cmd_d     = CMD_NONE;
                            refused_d = 1'b1;
                        end
                    end
                end
                S_LOSS: if (wait_done) begin
                    rst_out_d = 1'b0;
                    wait_d    = wait_ticks(TK_RST_HOLD);
                    st_d      = S_RSTLOW;
                end
                S_RSTLOW: if (wait_done) begin
                    pdn_d = 1'b0;
                    den_d = 1'b0;
                    pw_d  = 1'b0;
                    st_d  = S_OFF;
                end
                default: st_d = S_OFF;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= S_OFF;
            tick_cnt_q <= 16'h0000;
            wait_q     <= 16'h0000;
            guard_q    <= 16'h0000;
            timing_q   <= TIMING_RESET;
            cmd_q      <= CMD_NONE;
            pw_q       <= 1'b0;
            pw_word_q  <= 16'h0000;
            pd_pend_q  <= 1'b0;
            first_q    <= 1'b0;
            refused_q  <= 1'b0;
            go_q       <= 1'b0;
            sub_q      <= 8'h00;
            dat_q      <= 8'h00;
            rst_out_q  <= 1'b0;
            pdn_q      <= 1'b0;
            den_q      <= 1'b0;
            rdata      <= 16'h0000;
        end else begin
            st_q       <= st_d;
            tick_cnt_q <= tick_cnt_d;
            wait_q     <= wait_d;
            guard_q    <= guard_d;
            timing_q   <= timing_d;
            cmd_q      <= cmd_d;
            pw_q       <= pw_d;
            pw_word_q  <= pw_word_d;
            pd_pend_q  <= pd_pend_d;
            first_q    <= first_d;
            refused_q  <= refused_d;
            go_q       <= go_d;
            sub_q      <= sub_d;
            dat_q      <= dat_d;
            rst_out_q  <= rst_out_d;
            pdn_q      <= pdn_d;
            den_q      <= den_d;
            rdata      <= rdata_d;
        end
    end

    assign amp_reset_n   = rst_out_q;
    assign power_down_n  = pdn_q;
    assign dig_inputs_en = den_q;
endmodule : ampseq_top
`default_nettype wire

//--- hw/ampseq_pkg.sv
// constants and types shared by the amplifier start-up and shutdown host sequencer
package ampseq_pkg;
    // device register map, reached over the two-wire bus
    localparam logic [7:0] DEV_SHUTDOWN_CTRL = 8'h05;
    localparam logic [7:0] DEV_PWM_PERIOD    = 8'h1A;
    localparam logic [7:0] DEV_OSC_TRIM      = 8'h1B;
    localparam logic [7:0] SHUTDOWN_ENTER    = 8'h40;
    localparam logic [7:0] SHUTDOWN_EXIT     = 8'h00;
    localparam logic [7:0] TRIM_VALUE        = 8'h00;
    // local register map, software port
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_WRITE  = 4'h1;
    localparam logic [3:0] REG_TIMING = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [15:0] TIMING_RESET = 16'h0000;
    localparam int ST_REFUSED_BIT = 4;
    // command codes in CTRL[2:0]
    localparam logic [2:0] CMD_NONE  = 3'h0;
    localparam logic [2:0] CMD_INIT  = 3'h1;
    localparam logic [2:0] CMD_EXIT  = 3'h2;
    localparam logic [2:0] CMD_ENTER = 3'h3;
    localparam logic [2:0] CMD_PDOWN = 3'h4;
    localparam logic [2:0] CMD_LOSS  = 3'h5;
    // timing: clock and a 100 us tick that every wait counts in
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS       = 100000;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RST_LOW_US  = 100;
    localparam int T_RST_REL_US  = 13500;
    localparam int T_TRIM_US     = 50000;
    localparam int T_GUARD_US    = 240000;
    localparam int T_SD_US       = 1000;
    localparam int T_LOSS_US     = 2000;
    localparam int T_RST_HOLD_NS = 2000;
    localparam int TK_RST_LOW  = (T_RST_LOW_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int TK_RST_REL  = (T_RST_REL_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int TK_TRIM     = (T_TRIM_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int TK_GUARD    = (T_GUARD_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int TK_SD       = (T_SD_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int TK_LOSS     = (T_LOSS_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int TK_RST_HOLD = (T_RST_HOLD_NS + TICK_NS - 1) / TICK_NS;
    // 1.3 x t in ms equals 13 x t ticks of 100 us exactly
    localparam int PWM_SCALE_TICKS = 13;
    // two-wire bus quarter bit at 100 kHz
    localparam int I2C_QTR_CYCLES = 100;

    typedef enum logic [3:0] {
        S_OFF, S_RST, S_REL, S_TRIM, S_TRIMW, S_CFG, S_EXIT, S_EXITW,
        S_RUN, S_ENTER, S_ENTERW, S_SHUT, S_LOSS, S_RSTLOW
    } ampseq_state_e;

    typedef enum logic [1:0] {I_IDLE, I_START, I_BITS, I_STOP} ampseq_i2c_e;
endpackage : ampseq_pkg

//--- hw/ampseq_i2c_wr.sv
// two-wire bus master that sends one register write: address, sub-address, data
`timescale 1ns/1ps
`default_nettype none
module ampseq_i2c_wr
    import ampseq_pkg::*;
#(
    parameter int QTR = I2C_QTR_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       hold_low,
    input  wire logic       go,
    input  wire logic [6:0] dev_addr,
    input  wire logic [7:0] sub,
    input  wire logic [7:0] dat,
    input  wire logic       sda_i,
    output logic            busy_q,
    output logic            done_q,
    output logic            nack_q,
    output logic            scl_oe_q,
    output logic            sda_oe_q
);
    initial begin
        if (QTR < 2 || QTR > 65535) $error("QTR out of range");
    end

    ampseq_i2c_e ph_q, ph_d;
    logic [15:0] div_q, div_d;
    logic [1:0]  qt_q, qt_d;
    logic [4:0]  bit_q, bit_d;
    logic [26:0] sh_q, sh_d;
    logic        done_d, nack_d, busy_d, scl_d, sda_d;
    logic        sda_s1_q, sda_s2_q;
    logic        step;

    assign step = (div_q == 16'h0000);

    always_comb begin
        ph_d   = ph_q;
        div_d  = step ? 16'(QTR - 1) : div_q - 16'h0001;
        qt_d   = qt_q;
        bit_d  = bit_q;
        sh_d   = sh_q;
        done_d = 1'b0;
        nack_d = nack_q;
        scl_d  = scl_oe_q;
        sda_d  = sda_oe_q;
        busy_d = busy_q;
        case (ph_q)
            I_IDLE: begin
                scl_d = hold_low;
                sda_d = hold_low;
                if (go && !hold_low) begin
                    ph_d   = I_START;
                    busy_d = 1'b1;
                    nack_d = 1'b0;
                    qt_d   = 2'h0;
                    div_d  = 16'(QTR - 1);
                    bit_d  = 5'h00;
                    sh_d   = {dev_addr, 1'b0, 1'b1, sub, 1'b1, dat, 1'b1};
                end
            end
            I_START: if (step) begin
                if (qt_q == 2'h0) begin
                    sda_d = 1'b1;
                    qt_d  = 2'h1;
                end else begin
                    scl_d = 1'b1;
                    qt_d  = 2'h0;
                    ph_d  = I_BITS;
                end
            end
            I_BITS: if (step) begin
                qt_d = qt_q + 2'h1;
                case (qt_q)
                    2'h0: sda_d = ~sh_q[26];
                    2'h1: scl_d = 1'b0;
                    2'h2: begin
                        // acknowledge slots release the line, a high level means refused
                        if ((bit_q == 5'd8 || bit_q == 5'd17 || bit_q == 5'd26) && sda_s2_q) begin
                            nack_d = 1'b1;
                        end
                    end
                    default: begin
                        scl_d = 1'b1;
                        sh_d  = {sh_q[25:0], 1'b1};
                        bit_d = bit_q + 5'h01;
                        if (bit_q == 5'd26) begin
                            ph_d = I_STOP;
                        end
                    end
                endcase
            end
            I_STOP: if (step) begin
                qt_d = qt_q + 2'h1;
                case (qt_q)
                    2'h0: sda_d = 1'b1;
                    2'h1: scl_d = 1'b0;
                    2'h2: sda_d = 1'b0;
                    default: begin
                        ph_d   = I_IDLE;
                        busy_d = 1'b0;
                        done_d = 1'b1;
                    end
                endcase
            end
            default: ph_d = I_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q     <= I_IDLE;
            div_q    <= 16'h0000;
            qt_q     <= 2'h0;
            bit_q    <= 5'h00;
            sh_q     <= 27'h7FFFFFF;
            done_q   <= 1'b0;
            nack_q   <= 1'b0;
            busy_q   <= 1'b0;
            scl_oe_q <= 1'b1;
            sda_oe_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
        end else begin
            ph_q     <= ph_d;
            div_q    <= div_d;
            qt_q     <= qt_d;
            bit_q    <= bit_d;
            sh_q     <= sh_d;
            done_q   <= done_d;
            nack_q   <= nack_d;
            busy_q   <= busy_d;
            scl_oe_q <= scl_d;
            sda_oe_q <= sda_d;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
        end
    end
endmodule : ampseq_i2c_wr
`default_nettype wire

//--- sim/ampseq_dev_model.sv
// behavioural amplifier: two-wire register slave holding the sequencing registers
`timescale 1ns/1ps
`default_nettype none
module ampseq_dev_model #(
    parameter logic [6:0] ADDR = 7'h2A // arbitrary, same as the sequencer default
) (
    input wire logic scl,
    input wire logic sda,
    output logic     sda_pull
);
    logic [7:0] regs [256];
    logic [7:0] sh;
    logic [7:0] sub;
    int         bitn = 0;
    int         byten = 0;
    int         wr_count = 0;
    initial sda_pull = 1'b0;
    always @(negedge sda) if (scl === 1'b1) begin
        bitn = 0;
        byten = 0;
    end
    always @(posedge scl) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        bitn = bitn + 1;
    end
    // shutdown exits are taken at once, so the host's own guard is what gets tested
    always @(negedge scl) begin
        if (bitn == 8) sda_pull = byten != 0 || sh[7:1] == ADDR;
        if (bitn == 9) begin
            sda_pull = 1'b0;
            bitn = 0;
            if (byten == 1) sub = sh;
            if (byten == 2) regs[sub] = sh;
            if (byten == 2) wr_count = wr_count + 1;
            byten = byten + 1;
        end
    end
endmodule : ampseq_dev_model
`default_nettype wire

//--- sim/ampseq_top_properties.sv
// pin and register-port assertions for the sequencer top
`timescale 1ns/1ps
`default_nettype none
module ampseq_chk
    import ampseq_pkg::*;
#(parameter int TICK_CYC = TICK_CYCLES) (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        amp_reset_n,
    input wire logic        power_down_n,
    input wire logic        dig_inputs_en,
    input wire logic        scl_o,
    input wire logic        scl_oe,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe
);
    int lo_q;
    int hi_q;
    int pd_q;
    // cycles amp_reset_n has held its level and power_down_n has been low, so minimum waits can be measured
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lo_q <= 0;
            hi_q <= 0;
            pd_q <= 0;
        end else begin
            lo_q <= amp_reset_n ? 0 : lo_q + 1;
            hi_q <= amp_reset_n ? hi_q + 1 : 0;
            pd_q <= power_down_n ? 0 : pd_q + 1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    rdata_quiet_a: assert property ((!$past(rd) || $past(addr) > REG_STATUS) |-> rdata == 16'h0000)
        else $error("read data outside a reply");
    open_drain_a: assert property (!scl_o && !sda_o)
        else $error("bus line driven high");
    inputs_on_a: assert property ($rose(dig_inputs_en) |-> power_down_n && !amp_reset_n)
        else $error("inputs enabled out of order");
    rst_pulse_a: assert property ($rose(amp_reset_n) |-> lo_q >= TK_RST_LOW * TICK_CYC)
        else $error("reset pulse too short");
    rst_settle_a: assert property ($rose(sda_oe) && !scl_oe && amp_reset_n |-> hi_q >= TK_RST_REL * TICK_CYC)
        else $error("bus start too soon after reset");
    loss_wait_a: assert property ($fell(amp_reset_n) && !power_down_n |-> pd_q >= TK_LOSS * TICK_CYC)
        else $error("reset too soon after power-down");
    inputs_off_a: assert property ($fell(dig_inputs_en) |-> lo_q >= TK_RST_HOLD * TICK_CYC)
        else $error("inputs dropped too soon");
    timing_echo_a: assert property ($past(rd) && $past(addr) == REG_TIMING && $past(wr, 2)
        && $past(addr, 2) == REG_TIMING |-> rdata == $past(wdata, 2))
        else $error("timing register readback wrong");
endmodule : ampseq_chk
bind ampseq_top ampseq_chk #(.TICK_CYC(TICK_CYC)) i_ampseq_chk (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .amp_reset_n(amp_reset_n), .power_down_n(power_down_n), .dig_inputs_en(dig_inputs_en),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the amplifier start-up and shutdown sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ampseq_pkg::*;
;
    localparam int TCK = 4;
    typedef struct packed {logic [3:0] a; logic [15:0] d; logic w; logic [15:0] e;} ampseq_row_s;
    ampseq_row_s rows [6] = '{'{REG_CTRL, 16'h0, 1'b0, 16'h0}, '{REG_STATUS, 16'h0, 1'b0, 16'h0},
        '{REG_TIMING, 16'h0, 1'b0, TIMING_RESET}, '{4'h9, 16'h0, 1'b0, 16'h0},
        '{4'hA, 16'hFFFF, 1'b1, 16'h0}, '{REG_TIMING, 16'h0100, 1'b1, 16'h0100}};
    logic mclk, resetn, wr, rd, amp_reset_n, power_down_n, dig_inputs_en;
    logic scl_o, scl_oe, sda_o, sda_oe, sda_pull;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, v;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    int t0, tg;
    // both lines have pull-ups: high unless someone pulls them low
    wire logic scl_line = ~scl_oe;
    wire logic sda_line = ~(sda_oe | sda_pull);
    ampseq_top #(.TICK_CYC(TCK)) i_ampseq_top (
        .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .amp_reset_n(amp_reset_n), .power_down_n(power_down_n), .dig_inputs_en(dig_inputs_en),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe)
    );
    ampseq_dev_model i_ampseq_dev_model (.scl(scl_line), .sda(sda_line), .sda_pull(sda_pull));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 95000) begin
            failures = failures + 1;
            finish_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic w, input logic r);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= r;
    endtask : bus
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        bus(a, d, 1'b1, 1'b0);
        bus(a, d, 1'b0, 1'b0);
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a);
        bus(a, 16'h0, 1'b0, 1'b1);
        bus(a, 16'h0, 1'b0, 1'b0);
        #1 v = rdata;
    endtask : rd_reg
    task automatic wait_state(input logic [3:0] s);
        n = 0;
        do begin
            rd_reg(REG_STATUS);
            n = n + 1;
        end while (v[3:0] !== s && n < 60000);
        check(v[3:0], s);
    endtask : wait_state
    task automatic wait_wr(input int k);
        n = 0;
        while (i_ampseq_dev_model.wr_count < k && n < 60000) begin
            @(posedge mclk);
            n = n + 1;
        end
        check(i_ampseq_dev_model.wr_count == k, 1'b1);
        t0 = cyc;
    endtask : wait_wr
    initial begin
        addr = 4'h0;
        wdata = 16'h0;
        wr = 1'b0;
        rd = 1'b0;
        resetn = 1'b0;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        check({amp_reset_n, power_down_n, dig_inputs_en}, 3'b000);
        foreach (rows[i]) begin
            if (rows[i].w) bus(rows[i].a, rows[i].d, 1'b1, 1'b0);
            rd_reg(rows[i].a);
            check(v, rows[i].e);
        end
        wr_reg(REG_CTRL, 16'(CMD_INIT));
        repeat (4) @(posedge mclk);
        check({amp_reset_n, power_down_n, dig_inputs_en}, 3'b011);
        wait_wr(1);
        check(i_ampseq_dev_model.regs[DEV_OSC_TRIM], TRIM_VALUE);
        wait_state(S_CFG);
        check(cyc - t0 >= TK_TRIM * TCK, 1'b1);
        check(v[6:5], 2'b11);
        tg = t0;
        wr_reg(REG_CTRL, 16'(CMD_EXIT));
        wr_reg(REG_CTRL, 16'(CMD_EXIT));
        rd_reg(REG_CTRL);
        check(v[2:0], CMD_EXIT);
        rd_reg(REG_STATUS);
        check(v[4], 1'b1);
        wr_reg(REG_STATUS, 16'h0010);
        wait_wr(2);
        check(t0 - tg >= TK_GUARD * TCK, 1'b1);
        check(i_ampseq_dev_model.regs[DEV_SHUTDOWN_CTRL], SHUTDOWN_EXIT);
        wait_state(S_RUN);
        check(cyc - t0 >= TK_SD * TCK, 1'b1);
        check(v[4], 1'b0);
        wr_reg(REG_WRITE, 16'h2055);
        rd_reg(REG_STATUS);
        check(v[4], 1'b1);
        wr_reg(REG_WRITE, {i_ampseq_top.VOL_LAST, 8'h30});
        wait_wr(3);
        check(i_ampseq_dev_model.regs[i_ampseq_top.VOL_LAST], 8'h30);
        wr_reg(REG_CTRL, 16'(CMD_ENTER));
        wait_wr(4);
        check(i_ampseq_dev_model.regs[DEV_SHUTDOWN_CTRL], SHUTDOWN_ENTER);
        wait_state(S_SHUT);
        check(cyc - t0 >= (TK_SD + PWM_SCALE_TICKS) * TCK, 1'b1);
        wr_reg(REG_CTRL, 16'(CMD_LOSS));
        wait_state(S_OFF);
        check({amp_reset_n, power_down_n, dig_inputs_en}, 3'b000);
        wr_reg(REG_CTRL, 16'(CMD_INIT));
        wait_state(S_CFG);
        check(v[6:5], 2'b01);
        check(i_ampseq_dev_model.wr_count, 16'd5);
        wr_reg(REG_CTRL, 16'(CMD_PDOWN));
        wait_state(S_OFF);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
